// ---- siw_pkg.sv ----
`default_nettype none
package siw_pkg;
    // ----------
    // Register offsets
    // ----------
    localparam logic [7:0] ADDR_INT_CFG = 8'h03;
    localparam logic [7:0] ADDR_IRQ_EN = 8'h04;
    localparam logic [7:0] ADDR_UNLOCK_KEY = 8'h07;
    localparam logic [7:0] ADDR_WAKE_LOW = 8'h08;
    localparam logic [7:0] ADDR_WAKE_HIGH = 8'h09;
    // Low byte offset on the early sequencer revision
    localparam logic [7:0] ADDR_WAKE_LOW_ALT = 8'h0A;

    // ----------
    // Field positions
    // ----------
    localparam int BIT_PIN_DRIVE = 0;
    localparam int BIT_AMBIENT_IE = 0;
    localparam int BIT_PROX1_IE = 2;
    localparam int BIT_PROX2_IE = 3;
    localparam int BIT_PROX3_IE = 4;
    localparam int BIT_COMMAND_IE = 5;
    localparam logic [7:0] IRQ_EN_MASK = 8'h3D;

    // ----------
    // Reset values and key
    // ----------
    localparam logic [7:0] RST_INT_CFG = 8'h00;
    localparam logic [7:0] RST_IRQ_EN = 8'h00;
    localparam logic [7:0] RST_UNLOCK_KEY = 8'h00;
    localparam logic [7:0] RST_WAKE_LOW = 8'h00;
    localparam logic [7:0] RST_WAKE_HIGH = 8'h00;
    localparam logic [7:0] UNLOCK_VALUE = 8'h17;

    // ----------
    // Wake-up timing
    // ----------
    localparam int CLK_PERIOD_PS = 10000;
    localparam int WAKE_UNIT_PS = 31250000;
    localparam int WAKE_UNIT_CYCLES = (WAKE_UNIT_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam logic [11:0] WAKE_UNIT_LAST = 12'(WAKE_UNIT_CYCLES - 1);

    // ----------
    // Serial slave states and byte phases
    // ----------
    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_RX = 5'b00010,
        ST_ACK = 5'b00100,
        ST_TX = 5'b01000,
        ST_TXACK = 5'b10000
    } siw_state_e;

    localparam logic [1:0] PH_ADDR = 2'h0;
    localparam logic [1:0] PH_PTR = 2'h1;
    localparam logic [1:0] PH_DATA = 2'h2;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
endpackage
`default_nettype wire

// ---- siw_serial_slave.sv ----
`default_nettype none
module siw_serial_slave #(
    parameter logic [6:0] DEV_ADDR = 7'h2A
) (
    // Clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // Serial pins
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_oe_n,
    // Register side
    output logic [7:0] reg_addr,
    output logic wr_stb,
    output logic [7:0] wr_data,
    input wire logic [7:0] rd_data
);
    siw_pkg::siw_state_e st_r, st_nxt;
    logic scl_q_r, scl_p_r, sda_q_r, sda_p_r;
    logic [3:0] cnt_r, cnt_nxt;
    logic [7:0] sh_r, sh_nxt;
    logic [7:0] ptr_r, ptr_nxt;
    logic [1:0] ph_r, ph_nxt;
    logic rw_r, rw_nxt;
    logic oe_n_r, oe_n_nxt;
    logic stb_r, stb_nxt;
    logic [7:0] wd_r, wd_nxt;
    logic scl_rise, scl_fall, start_c, stop_c;

    // ----------
    // Pin edge detection
    // ----------
    assign scl_rise = scl_q_r & ~scl_p_r;
    assign scl_fall = ~scl_q_r & scl_p_r;
    assign start_c = scl_q_r & scl_p_r & sda_p_r & ~sda_q_r;
    assign stop_c = scl_q_r & scl_p_r & ~sda_p_r & sda_q_r;

    // Next-state logic; pointer auto-increments per written byte and per master-acked read byte
    always_comb begin
        st_nxt = st_r;
        cnt_nxt = cnt_r;
        sh_nxt = sh_r;
        ptr_nxt = ptr_r;
        ph_nxt = ph_r;
        rw_nxt = rw_r;
        oe_n_nxt = oe_n_r;
        stb_nxt = 1'b0;
        wd_nxt = wd_r;
        if (start_c) begin
            st_nxt = siw_pkg::ST_RX;
            cnt_nxt = 4'h0;
            ph_nxt = siw_pkg::PH_ADDR;
            oe_n_nxt = 1'b1;
        end else if (stop_c) begin
            st_nxt = siw_pkg::ST_IDLE;
            oe_n_nxt = 1'b1;
        end else begin
            case (st_r)
                siw_pkg::ST_IDLE: begin
                    oe_n_nxt = 1'b1;
                end
                siw_pkg::ST_RX: begin
                    if (scl_rise) begin
                        sh_nxt = {sh_r[6:0], sda_q_r};
                        cnt_nxt = cnt_r + 4'h1;
                    end else if (scl_fall && cnt_r == siw_pkg::BITS_PER_BYTE) begin
                        cnt_nxt = 4'h0;
                        st_nxt = siw_pkg::ST_ACK;
                        oe_n_nxt = 1'b0;
                        if (ph_r == siw_pkg::PH_ADDR) begin
                            rw_nxt = sh_r[0];
                            // Not our address: stay off the bus
                            if (sh_r[7:1] != DEV_ADDR) begin
                                st_nxt = siw_pkg::ST_IDLE;
                                oe_n_nxt = 1'b1;
                            end
                        end else if (ph_r == siw_pkg::PH_PTR) begin
                            ptr_nxt = sh_r;
                        end else begin
                            stb_nxt = 1'b1;
                            wd_nxt = sh_r;
                        end
                    end
                end
                siw_pkg::ST_ACK: begin
                    if (scl_fall) begin
                        oe_n_nxt = 1'b1;
                        st_nxt = siw_pkg::ST_RX;
                        if (ph_r == siw_pkg::PH_ADDR && rw_r) begin
                            sh_nxt = rd_data;
                            oe_n_nxt = rd_data[7];
                            st_nxt = siw_pkg::ST_TX;
                            ph_nxt = siw_pkg::PH_DATA;
                        end else if (ph_r == siw_pkg::PH_ADDR) begin
                            ph_nxt = siw_pkg::PH_PTR;
                        end else if (ph_r == siw_pkg::PH_PTR) begin
                            ph_nxt = siw_pkg::PH_DATA;
                        end else begin
                            ptr_nxt = ptr_r + 8'h01;
                        end
                    end
                end
                siw_pkg::ST_TX: begin
                    if (scl_rise) begin
                        cnt_nxt = cnt_r + 4'h1;
                    end else if (scl_fall) begin
                        if (cnt_r == siw_pkg::BITS_PER_BYTE) begin
                            cnt_nxt = 4'h0;
                            oe_n_nxt = 1'b1;
                            st_nxt = siw_pkg::ST_TXACK;
                        end else begin
                            sh_nxt = {sh_r[6:0], 1'b0};
                            oe_n_nxt = sh_r[6];
                        end
                    end
                end
                siw_pkg::ST_TXACK: begin
                    // Master nack ends the read; ack moves to the next byte
                    if (scl_rise) begin
                        if (sda_q_r) begin
                            st_nxt = siw_pkg::ST_IDLE;
                        end else begin
                            ptr_nxt = ptr_r + 8'h01;
                        end
                    end else if (scl_fall) begin
                        sh_nxt = rd_data;
                        oe_n_nxt = rd_data[7];
                        st_nxt = siw_pkg::ST_TX;
                    end
                end
                default: begin
                    st_nxt = siw_pkg::ST_IDLE;
                    oe_n_nxt = 1'b1;
                end
            endcase
        end
    end

    // State registers
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            st_r <= siw_pkg::ST_IDLE;
            scl_q_r <= 1'b1;
            scl_p_r <= 1'b1;
            sda_q_r <= 1'b1;
            sda_p_r <= 1'b1;
            cnt_r <= 4'h0;
            sh_r <= 8'h00;
            ptr_r <= 8'h00;
            ph_r <= siw_pkg::PH_ADDR;
            rw_r <= 1'b0;
            oe_n_r <= 1'b1;
            stb_r <= 1'b0;
            wd_r <= 8'h00;
        end else begin
            st_r <= st_nxt;
            scl_q_r <= scl_in;
            scl_p_r <= scl_q_r;
            sda_q_r <= sda_in;
            sda_p_r <= sda_q_r;
            cnt_r <= cnt_nxt;
            sh_r <= sh_nxt;
            ptr_r <= ptr_nxt;
            ph_r <= ph_nxt;
            rw_r <= rw_nxt;
            oe_n_r <= oe_n_nxt;
            stb_r <= stb_nxt;
            wd_r <= wd_nxt;
        end
    end

    assign sda_oe_n = oe_n_r;
    assign reg_addr = ptr_r;
    assign wr_stb = stb_r;
    assign wr_data = wd_r;
endmodule
`default_nettype wire

// ---- siw_irq_wake.sv ----
// ----------
// Overview of operation
// - With pin drive off the interrupt pin is never driven.
// - With pin drive on the pin is pulled low while any flag meets its set enable bit, the ambient flag only with visible or UV selected.
// - Enable bit 5 lets the command flag assert the pin, and only then.
// - Enable bit 4 lets the third proximity flag assert the pin, and only then.
// - Enable bit 3 lets the second proximity flag assert the pin, and only then.
// - Enable bit 2 lets the first proximity flag assert the pin, and only then.
// - Enable bit 0 lets ambient or UV completion assert the pin, and only then.
// - The ambient source counts only while visible or UV is in the channel list.
// - The low byte at 0x08 (0x0A with EARLY_REV_MAP) and the high byte form one 16-bit wake period.
// - Autonomous wake-ups come every period times 31.25 us.
// - Each wake-up requests every measurement selected in the channel list.
// - The high period byte is its own read/write register, reset to zero: after the low byte at 0x09, or before it at 0x08 with EARLY_REV_MAP.
// ----------
`default_nettype none
module siw_irq_wake #(
    parameter logic [6:0] DEV_ADDR = 7'h2A,
    parameter logic EARLY_REV_MAP = 1'b0
) (
    // Clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // Serial register port
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n,
    // Interrupt pin
    output logic int_out,
    output logic int_oe_n,
    // Status flags from the sequencer
    input wire logic command_flag,
    input wire logic prox_ch1_flag,
    input wire logic prox_ch2_flag,
    input wire logic prox_ch3_flag,
    input wire logic ambient_flag,
    // Measurement selection
    input wire logic [7:0] channel_select_list,
    input wire logic visible_channel,
    input wire logic uv_channel,
    // Wake requests to the measurement engine
    output logic wake_pulse,
    output logic [7:0] wake_channels,
    output logic key_unlocked
);
    logic [7:0] int_cfg_r, int_cfg_nxt;
    logic [7:0] irq_en_r, irq_en_nxt;
    logic [7:0] unlock_key_r, unlock_key_nxt;
    logic [7:0] wake_period_low_r, wake_period_low_nxt;
    logic [7:0] wake_period_high_r, wake_period_high_nxt;
    logic [7:0] rd_data_r, rd_data_nxt;
    logic [7:0] reg_addr, wr_data;
    logic wr_stb, slave_oe_n;
    logic [7:0] addr_low, addr_high;
    logic [15:0] wake_period;
    logic [11:0] unit_cnt_r, unit_cnt_nxt;
    logic [15:0] period_cnt_r, period_cnt_nxt;
    logic wake_r, wake_nxt;
    logic [7:0] chans_r, chans_nxt;
    logic int_oe_n_r, int_oe_n_nxt;
    logic key_ok_r, key_ok_nxt;
    logic pending;

    // ----------
    // Serial slave
    // ----------
    siw_serial_slave #(
        .DEV_ADDR(DEV_ADDR)
    ) u_slave (
        .clock(clock),
        .sys_rst(sys_rst),
        .scl_in(scl_in),
        .sda_in(sda_in),
        .sda_oe_n(slave_oe_n),
        .reg_addr(reg_addr),
        .wr_stb(wr_stb),
        .wr_data(wr_data),
        .rd_data(rd_data_r)
    );

    // ----------
    // Register file
    // ----------
    // Period byte addresses follow the sequencer revision strap
    assign addr_low = EARLY_REV_MAP ? siw_pkg::ADDR_WAKE_LOW_ALT : siw_pkg::ADDR_WAKE_LOW;
    assign addr_high = EARLY_REV_MAP ? siw_pkg::ADDR_WAKE_LOW : siw_pkg::ADDR_WAKE_HIGH;

    // Writes and registered read mux; unmapped offsets read zero
    always_comb begin
        int_cfg_nxt = int_cfg_r;
        irq_en_nxt = irq_en_r;
        unlock_key_nxt = unlock_key_r;
        wake_period_low_nxt = wake_period_low_r;
        wake_period_high_nxt = wake_period_high_r;
        if (wr_stb) begin
            if (reg_addr == siw_pkg::ADDR_INT_CFG) begin
                int_cfg_nxt = wr_data & 8'h01;
            end
            if (reg_addr == siw_pkg::ADDR_IRQ_EN) begin
                irq_en_nxt = wr_data & siw_pkg::IRQ_EN_MASK;
            end
            if (reg_addr == siw_pkg::ADDR_UNLOCK_KEY) begin
                unlock_key_nxt = wr_data;
            end
            if (reg_addr == addr_low) begin
                wake_period_low_nxt = wr_data;
            end
            if (reg_addr == addr_high) begin
                wake_period_high_nxt = wr_data;
            end
        end
        rd_data_nxt = 8'h00;
        if (reg_addr == siw_pkg::ADDR_INT_CFG) begin
            rd_data_nxt = int_cfg_r;
        end else if (reg_addr == siw_pkg::ADDR_IRQ_EN) begin
            rd_data_nxt = irq_en_r;
        end else if (reg_addr == siw_pkg::ADDR_UNLOCK_KEY) begin
            rd_data_nxt = unlock_key_r;
        end else if (reg_addr == addr_low) begin
            rd_data_nxt = wake_period_low_r;
        end else if (reg_addr == addr_high) begin
            rd_data_nxt = wake_period_high_r;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            int_cfg_r <= siw_pkg::RST_INT_CFG;
            irq_en_r <= siw_pkg::RST_IRQ_EN;
            unlock_key_r <= siw_pkg::RST_UNLOCK_KEY;
            wake_period_low_r <= siw_pkg::RST_WAKE_LOW;
            wake_period_high_r <= siw_pkg::RST_WAKE_HIGH;
            rd_data_r <= 8'h00;
        end else begin
            int_cfg_r <= int_cfg_nxt;
            irq_en_r <= irq_en_nxt;
            unlock_key_r <= unlock_key_nxt;
            wake_period_low_r <= wake_period_low_nxt;
            wake_period_high_r <= wake_period_high_nxt;
            rd_data_r <= rd_data_nxt;
        end
    end

    // ----------
    // Interrupt pin
    // ----------
    // Flags are levels held by the sequencer until it clears them
    always_comb begin
        pending = 1'b0;
        if (irq_en_r[siw_pkg::BIT_COMMAND_IE] && command_flag) begin
            pending = 1'b1;
        end
        if (irq_en_r[siw_pkg::BIT_PROX3_IE] && prox_ch3_flag) begin
            pending = 1'b1;
        end
        if (irq_en_r[siw_pkg::BIT_PROX2_IE] && prox_ch2_flag) begin
            pending = 1'b1;
        end
        if (irq_en_r[siw_pkg::BIT_PROX1_IE] && prox_ch1_flag) begin
            pending = 1'b1;
        end
        // Ambient only counts with visible or UV selected
        if (irq_en_r[siw_pkg::BIT_AMBIENT_IE] && ambient_flag && (visible_channel || uv_channel)) begin
            pending = 1'b1;
        end
        // Enable is active low: low pulls the pin down, high releases it
        int_oe_n_nxt = ~(int_cfg_r[siw_pkg::BIT_PIN_DRIVE] && pending);
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            int_oe_n_r <= 1'b1;
        end else begin
            int_oe_n_r <= int_oe_n_nxt;
        end
    end

    // ----------
    // Wake-up timer
    // ----------
    assign wake_period = {wake_period_high_r, wake_period_low_r};

    // A zero period or a locked key keeps the timer idle
    always_comb begin
        key_ok_nxt = (unlock_key_r == siw_pkg::UNLOCK_VALUE);
        unit_cnt_nxt = unit_cnt_r;
        period_cnt_nxt = period_cnt_r;
        wake_nxt = 1'b0;
        chans_nxt = chans_r;
        if (!key_ok_r || wake_period == 16'h0000) begin
            unit_cnt_nxt = 12'h000;
            period_cnt_nxt = 16'h0000;
        end else if (unit_cnt_r != siw_pkg::WAKE_UNIT_LAST) begin
            unit_cnt_nxt = unit_cnt_r + 12'h001;
        end else begin
            // One 31.25 us unit has elapsed
            unit_cnt_nxt = 12'h000;
            if (period_cnt_r + 16'h0001 >= wake_period) begin
                period_cnt_nxt = 16'h0000;
                wake_nxt = 1'b1;
                chans_nxt = channel_select_list;
            end else begin
                period_cnt_nxt = period_cnt_r + 16'h0001;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            key_ok_r <= 1'b0;
            unit_cnt_r <= 12'h000;
            period_cnt_r <= 16'h0000;
            wake_r <= 1'b0;
            chans_r <= 8'h00;
        end else begin
            key_ok_r <= key_ok_nxt;
            unit_cnt_r <= unit_cnt_nxt;
            period_cnt_r <= period_cnt_nxt;
            wake_r <= wake_nxt;
            chans_r <= chans_nxt;
        end
    end

    // ----------
    // Outputs
    // ----------
    // Both pins only ever drive low; data level is fixed at zero
    assign sda_out = 1'b0;
    assign int_out = 1'b0;
    assign sda_oe_n = slave_oe_n;
    assign int_oe_n = int_oe_n_r;
    assign wake_pulse = wake_r;
    assign wake_channels = chans_r;
    assign key_unlocked = key_ok_r;
endmodule
`default_nettype wire

// ---- siw_irq_wake_sva.sv ----
`default_nettype none
module siw_irq_wake_chk (
    // Clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // Pins
    input wire logic sda_out,
    input wire logic int_out,
    input wire logic int_oe_n,
    // Status flags and selection
    input wire logic command_flag,
    input wire logic prox_ch1_flag,
    input wire logic prox_ch2_flag,
    input wire logic prox_ch3_flag,
    input wire logic ambient_flag,
    input wire logic [7:0] channel_select_list,
    input wire logic visible_channel,
    input wire logic uv_channel,
    // Wake side
    input wire logic wake_pulse,
    input wire logic [7:0] wake_channels,
    input wire logic key_unlocked
);
    localparam int UNIT_CYC = 3125;
    logic any_src;
    logic [31:0] gap_r, gap_nxt;
    logic seen_r, seen_nxt;
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);
    // Any source that could pull the pin, enables aside
    assign any_src = command_flag | prox_ch1_flag | prox_ch2_flag | prox_ch3_flag |
        (ambient_flag & (visible_channel | uv_channel));
    // Cycles since the last wake; only trusted once one wake has been seen
    always_comb begin
        gap_nxt = wake_pulse ? 32'h1 : gap_r + 32'h1;
        seen_nxt = seen_r | wake_pulse;
    end
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            gap_r <= 32'h0;
            seen_r <= 1'b0;
        end else begin
            gap_r <= gap_nxt;
            seen_r <= seen_nxt;
        end
    end
    // ----------
    // Named steps
    // ----------
    sequence s_quiet;
        !any_src [*2];
    endsequence
    sequence s_repeat_wake;
        wake_pulse && seen_r;
    endsequence
    // ----------
    // Properties
    // ----------
    pin_fall_a: assert property ($fell(int_oe_n) |-> $past(any_src))
        else $error("pin pulled with no source");
    pin_release_a: assert property (s_quiet |-> int_oe_n)
        else $error("pin held with nothing pending");
    pin_pull_only_a: assert property (int_out == 1'b0 && sda_out == 1'b0)
        else $error("pin data level not low");
    wake_single_a: assert property (wake_pulse |=> !wake_pulse)
        else $error("wake pulse longer than one cycle");
    wake_list_a: assert property (wake_pulse |-> wake_channels == $past(channel_select_list))
        else $error("wake channel list not captured");
    wake_hold_a: assert property (!wake_pulse && !$past(sys_rst) |-> $stable(wake_channels))
        else $error("wake list changed between wakes");
    wake_spacing_a: assert property (s_repeat_wake |-> gap_r % UNIT_CYC == 0)
        else $error("wake gap not whole units");
    wake_key_a: assert property (wake_pulse |-> key_unlocked)
        else $error("wake while key not written");
endmodule
bind siw_irq_wake siw_irq_wake_chk siw_irq_wake_chk_inst (.clock(clock), .sys_rst(sys_rst), .sda_out(sda_out),
    .int_out(int_out), .int_oe_n(int_oe_n), .command_flag(command_flag), .prox_ch1_flag(prox_ch1_flag),
    .prox_ch2_flag(prox_ch2_flag), .prox_ch3_flag(prox_ch3_flag), .ambient_flag(ambient_flag),
    .channel_select_list(channel_select_list), .visible_channel(visible_channel), .uv_channel(uv_channel),
    .wake_pulse(wake_pulse), .wake_channels(wake_channels), .key_unlocked(key_unlocked));
`default_nettype wire

// ---- siw_host_model.sv ----
`default_nettype none
module siw_host_model (
    // Clock
    input wire logic clock,
    // Serial pins, data resolved outside
    input wire logic sda_in,
    output logic scl,
    output logic sda_oe_n
);
    timeunit 1ns;
    timeprecision 1ps;
    // Six cycles a phase keeps well above the four-cycle minimum
    localparam int HALF = 6;
    logic [6:0] dev;
    initial begin
        scl = 1'b1;
        sda_oe_n = 1'b1;
        dev = 7'h2A;
    end
    // ----------
    // Bus primitives, all changes just after an edge
    // ----------
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    // Start or repeated start; leaves the clock line low
    task automatic start_cond();
        sda_oe_n = 1'b1;
        tick(HALF);
        scl = 1'b1;
        tick(HALF);
        sda_oe_n = 1'b0;
        tick(HALF);
        scl = 1'b0;
        tick(HALF);
    endtask
    task automatic stop_cond();
        sda_oe_n = 1'b0;
        tick(HALF);
        scl = 1'b1;
        tick(HALF);
        sda_oe_n = 1'b1;
        tick(HALF);
    endtask
    // Data only moves while the clock line is low
    task automatic bit_x(input logic b, output logic r);
        sda_oe_n = b;
        tick(HALF);
        scl = 1'b1;
        tick(HALF);
        r = sda_in;
        scl = 1'b0;
        tick(HALF);
    endtask
    task automatic byte_x(input logic [7:0] d, output logic [7:0] r, output logic nak);
        for (int i = 7; i >= 0; i--) bit_x(d[i], r[i]);
        bit_x(1'b1, nak);
    endtask
    // ----------
    // Register transfers
    // ----------
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d, output logic nak);
        logic [7:0] dum;
        logic n0, n1, n2;
        start_cond();
        byte_x({dev, 1'b0}, dum, n0);
        byte_x(a, dum, n1);
        byte_x(d, dum, n2);
        stop_cond();
        nak = n0 | n1 | n2;
    endtask
    // Single byte read ends with a master nack
    task automatic read_reg(input logic [7:0] a, output logic [7:0] d, output logic nak);
        logic [7:0] dum;
        logic n0, n1, n2, n3;
        start_cond();
        byte_x({dev, 1'b0}, dum, n0);
        byte_x(a, dum, n1);
        start_cond();
        byte_x({dev, 1'b1}, dum, n2);
        byte_x(8'hFF, d, n3);
        stop_cond();
        nak = n0 | n1 | n2;
    endtask
endmodule
`default_nettype wire

// ---- siw_irq_wake_tb.sv ----
`default_nettype none
module siw_irq_wake_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int UNIT_CYC = 3125;
    logic clock, sys_rst, vis_sel, uv_sel, scl, host_oe_n, sda_oe_n, sda_out, int_out, int_oe_n, early_oe_n;
    logic wake_pulse, key_unlocked, nak;
    logic [5:0] flg;
    logic [7:0] chan_list, wake_channels, rd;
    logic [7:0] addrs [5] = '{8'h03, 8'h04, 8'h07, 8'h08, 8'h09};
    int num_errors = 0;
    int cmp_count = 0;
    int n;
    // Open-drain data line with pull-up
    wire logic sda = host_oe_n & sda_oe_n & early_oe_n;
    siw_irq_wake siw_irq_wake_inst (.clock(clock), .sys_rst(sys_rst), .scl_in(scl), .sda_in(sda),
        .sda_out(sda_out), .sda_oe_n(sda_oe_n), .int_out(int_out), .int_oe_n(int_oe_n),
        .command_flag(flg[5]), .prox_ch1_flag(flg[2]), .prox_ch2_flag(flg[3]), .prox_ch3_flag(flg[4]),
        .ambient_flag(flg[0]), .channel_select_list(chan_list), .visible_channel(vis_sel),
        .uv_channel(uv_sel), .wake_pulse(wake_pulse), .wake_channels(wake_channels),
        .key_unlocked(key_unlocked));
    siw_host_model siw_host_model_inst (.clock(clock), .sda_in(sda), .scl(scl), .sda_oe_n(host_oe_n));
    // Early period map on a second address; only its data pin matters
    siw_irq_wake #(.DEV_ADDR(7'h3C), .EARLY_REV_MAP(1'b1)) siw_irq_wake_early_inst (.clock(clock),
        .sys_rst(sys_rst), .scl_in(scl), .sda_in(sda), .sda_out(), .sda_oe_n(early_oe_n), .int_out(),
        .int_oe_n(), .command_flag(1'b0), .prox_ch1_flag(1'b0), .prox_ch2_flag(1'b0), .prox_ch3_flag(1'b0),
        .ambient_flag(1'b0), .channel_select_list(8'h00), .visible_channel(1'b0), .uv_channel(1'b0),
        .wake_pulse(), .wake_channels(), .key_unlocked());
    // ----------
    // Helpers
    // ----------
    task automatic report_and_stop();
        if (num_errors == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic check(input string nm, input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge clock);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        siw_host_model_inst.write_reg(a, d, nak);
        check("write ack", {7'h00, nak}, 8'h00);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] exp, input string nm);
        siw_host_model_inst.read_reg(a, rd, nak);
        check(nm, rd, exp);
    endtask
    // Bounded wait; a required wake that never comes ends the run
    task automatic wait_wake(input int lim, input logic must);
        n = 0;
        while (wake_pulse !== 1'b1 && n < lim) begin
            tick(1);
            n++;
        end
        if (must && n >= lim) begin
            check("wake timeout", {7'h00, wake_pulse}, 8'h01);
            report_and_stop();
        end
    endtask
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    // ----------
    // Main sequence
    // ----------
    initial begin
        sys_rst = 1'b1;
        flg = 6'h00;
        chan_list = 8'hA5;
        vis_sel = 1'b1;
        uv_sel = 1'b0;
        repeat (16) @(posedge clock);
        #1;
        sys_rst = 1'b0;
        tick(2);
        foreach (addrs[k]) rdc(addrs[k], 8'h00, "reset value");
        // Drive off: every source pending, pin must stay released
        wr(8'h04, 8'hFF);
        rdc(8'h04, 8'h3D, "enable mask");
        flg = 6'h3D;
        tick(3);
        check("pin drive off", {7'h00, int_oe_n}, 8'h01);
        flg = 6'h00;
        wr(8'h03, 8'h01);
        rdc(8'h03, 8'h01, "output config");
        wr(8'h09, 8'h5A);
        rdc(8'h09, 8'h5A, "period high");
        wr(8'h0A, 8'h55);
        rdc(8'h0A, 8'h00, "unmapped offset");
        // Foreign address must not be acknowledged
        siw_host_model_inst.dev = 7'h2B;
        siw_host_model_inst.write_reg(8'h03, 8'h00, nak);
        check("foreign address nack", {7'h00, nak}, 8'h01);
        siw_host_model_inst.dev = 7'h2A;
        // Early map: low byte at 0x0A, high at 0x08, 0x09 unmapped
        siw_host_model_inst.dev = 7'h3C;
        wr(8'h0A, 8'h33);
        wr(8'h08, 8'h44);
        rdc(8'h0A, 8'h33, "early low");
        rdc(8'h08, 8'h44, "early high");
        rdc(8'h09, 8'h00, "early unmapped");
        siw_host_model_inst.dev = 7'h2A;
        // One enable at a time against every source
        for (int i = 0; i < 6; i++) if (i != 1) begin
            wr(8'h04, 8'(1 << i));
            for (int j = 0; j < 6; j++) if (j != 1) begin
                flg = 6'(1 << j);
                tick(3);
                check("irq pin", {7'h00, int_oe_n}, {7'h00, 1'(i != j)});
                flg = 6'h00;
                tick(3);
                check("irq release", {7'h00, int_oe_n}, 8'h01);
            end
        end
        // Ambient source counts only with visible or UV selected
        wr(8'h04, 8'h01);
        vis_sel = 1'b0;
        flg = 6'h01;
        tick(3);
        check("ambient unselected", {7'h00, int_oe_n}, 8'h01);
        uv_sel = 1'b1;
        tick(3);
        check("ambient uv", {7'h00, int_oe_n}, 8'h00);
        flg = 6'h00;
        // Period of one unit; no wake until the key is written
        wr(8'h08, 8'h01);
        wr(8'h09, 8'h00);
        rdc(8'h08, 8'h01, "period low");
        wait_wake(4000, 1'b0);
        check("wake while locked", {7'h00, wake_pulse}, 8'h00);
        wr(8'h07, 8'h17);
        check("unlocked", {7'h00, key_unlocked}, 8'h01);
        chan_list = 8'h5C;
        wait_wake(2 * UNIT_CYC, 1'b1);
        check("wake list", wake_channels, 8'h5C);
        chan_list = 8'h3A;
        tick(1);
        wait_wake(UNIT_CYC + 10, 1'b1);
        check("wake gap", {7'h00, 1'(n == UNIT_CYC - 1)}, 8'h01);
        check("second list", wake_channels, 8'h3A);
        report_and_stop();
    end
endmodule
`default_nettype wire
